/* File: common/adc_seq_pkg.sv */
// package: register map, field layout and types of the conversion sequencer
`default_nettype none
package adc_seq_pkg;
    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CONTROL_A = 8'h00; // enable
    localparam logic [ADDR_W-1:0] OFS_DIVIDER = 8'h04; // clock divider
    localparam logic [ADDR_W-1:0] OFS_TIMING = 8'h08; // tick count, reference
    localparam logic [ADDR_W-1:0] OFS_HOLD = 8'h0C; // sample hold length
    localparam logic [ADDR_W-1:0] OFS_ACC_CTRL = 8'h10; // count, repeat
    localparam logic [ADDR_W-1:0] OFS_MUX_POS = 8'h14; // positive input
    localparam logic [ADDR_W-1:0] OFS_MUX_NEG = 8'h18; // negative input
    localparam logic [ADDR_W-1:0] OFS_COMMAND = 8'h1C; // start, mode, two-input
    localparam logic [ADDR_W-1:0] OFS_INT_EN = 8'h20; // interrupt enables
    localparam logic [ADDR_W-1:0] OFS_INT_FLAG = 8'h24; // sticky flags, w1c
    localparam logic [ADDR_W-1:0] OFS_SAMPLE = 8'h28; // latest sample, ro
    localparam logic [ADDR_W-1:0] OFS_RESULT = 8'h2C; // result, ro
    localparam logic [ADDR_W-1:0] OFS_WIN_CTRL = 8'h30; // window mode
    localparam logic [ADDR_W-1:0] OFS_WIN_LO = 8'h34; // low threshold
    localparam logic [ADDR_W-1:0] OFS_WIN_HI = 8'h38; // high threshold
    // field positions and widths
    localparam int ENABLE_BIT = 0;
    localparam int DIV_LSB = 0;
    localparam int DIV_W = 3;
    localparam int TICK_LSB = 0;
    localparam int TICK_W = 7;
    localparam int REF_LSB = 8;
    localparam int REF_W = 3;
    localparam int HOLD_LSB = 0;
    localparam int HOLD_W = 8;
    localparam int CNT_LSB = 0;
    localparam int REPEAT_BIT = 5;
    localparam int MUX_LSB = 0;
    localparam int MUX_W = 6;
    localparam int START_LSB = 0;
    localparam int START_W = 3;
    localparam int MODE_LSB = 4;
    localparam int MODE_W = 3;
    localparam int TWO_IN_BIT = 7;
    localparam int WIN_MODE_LSB = 0;
    localparam int THR_LSB = 0;
    localparam int THR_W = 16;
    // flag bit positions
    localparam int FLG_RES = 0;
    localparam int FLG_SMP = 1;
    localparam int FLG_WIN = 2;
    localparam int FLG_OVR = 3;
    localparam int FLG_W = 4;
    // reset values
    localparam logic [DATA_W-1:0] RST_ZERO = 32'h0000_0000;
    localparam logic [THR_W-1:0] RST_WIN_HI = 16'hFFFF;
    // operation modes
    localparam logic [MODE_W-1:0] MODE_SINGLE8 = 3'h0;
    localparam logic [MODE_W-1:0] MODE_SINGLE12 = 3'h1;
    localparam logic [MODE_W-1:0] MODE_SERIES = 3'h2;
    localparam logic [MODE_W-1:0] MODE_SERIES_SC = 3'h3;
    localparam logic [MODE_W-1:0] MODE_BURST = 3'h4;
    localparam logic [MODE_W-1:0] MODE_BURST_SC = 3'h5;
    // start field codes
    localparam logic [START_W-1:0] START_NONE = 3'h0;
    localparam logic [START_W-1:0] START_NOW = 3'h1;
    localparam logic [START_W-1:0] START_MUXWR = 3'h2;
    localparam logic [START_W-1:0] START_EVENT = 3'h3;
    localparam logic [START_W-1:0] START_ABORT = 3'h4;
    // window compare modes
    localparam logic [2:0] WIN_OFF = 3'h0;
    localparam logic [2:0] WIN_BELOW = 3'h1;
    localparam logic [2:0] WIN_ABOVE = 3'h2;
    localparam logic [2:0] WIN_INSIDE = 3'h3;
    localparam logic [2:0] WIN_OUTSIDE = 3'h4;
    // converter code limits
    localparam logic signed [12:0] SE_MAX = 13'sh0FFF;
    localparam logic signed [12:0] DF_MAX = 13'sh07FF;
    localparam logic signed [12:0] DF_MIN = 13'sh1800;
    localparam logic [3:0] CNT_MAX = 4'hA;
    localparam logic [3:0] SCALE_BASE = 4'h4;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // sequencer states
    typedef enum logic {ST_IDLE, ST_BUSY} seq_state_t;
    // converter core answer
    typedef struct packed {
        logic done;
        logic signed [12:0] code;
    } conv_in_t;
    // settings driven to the analog front end
    typedef struct packed {
        logic enable;
        logic [REF_W-1:0] reference_choice;
        logic [DIV_W-1:0] clock_divider_select;
        logic [TICK_W-1:0] tick_count;
        logic [HOLD_W-1:0] sample_hold_length;
        logic [MUX_W-1:0] positive_input_select;
        logic [MUX_W-1:0] negative_input_select;
        logic two_input_select;
    } afe_cfg_t;
endpackage
`default_nettype wire

/* File: design/adc_conversion_sequencer.sv */
// module: conversion sequencer with axi4-lite register file
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`default_nettype none
module adc_conversion_sequencer
    import adc_seq_pkg::*;
#(
    parameter int CNT_W = 4, // accumulation_count width
    parameter int ACC_W = 24 // accumulator width, no overflow at 1024
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic trig_event,
    input wire conv_in_t conv_in,
    output logic conv_start,
    output logic conv_abort,
    output afe_cfg_t afe_cfg,
    output logic irq
);
    // bus handshake state
    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [ADDR_W-1:0] waddr_ff; // captured write address
    logic [DATA_W-1:0] wdata_ff, rdata_ff; // captured write data, read answer
    logic [3:0] wstrb_ff;
    // software settings
    logic enable_ff, repeat_ff, two_in_ff;
    logic [DIV_W-1:0] div_ff;
    logic [TICK_W-1:0] tick_ff;
    logic [REF_W-1:0] ref_ff;
    logic [HOLD_W-1:0] hold_ff;
    logic [CNT_W-1:0] cnt_sel_ff; // accumulation_count
    logic [MUX_W-1:0] pos_ff, neg_ff;
    logic [START_W-1:0] start_ff; // trigger selection
    logic [MODE_W-1:0] mode_ff;
    logic [FLG_W-1:0] inten_ff, flags_ff;
    logic [2:0] win_mode_ff;
    logic [THR_W-1:0] win_lo_ff, win_hi_ff;
    // sequencer state
    seq_state_t state_ff;
    logic [10:0] done_cnt_ff; // conversions taken into current sum
    logic signed [ACC_W-1:0] acc_ff;
    logic [15:0] sample_ff;
    logic [DATA_W-1:0] result_ff;
    logic conv_start_ff, conv_abort_ff, irq_ff;

    // byte-lane merge of a write into the old word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] st);
        logic [31:0] m;
        m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
        return (old & ~m) | (wd & m);
    endfunction

    // register view at an address, unmapped reads zero
    function automatic logic [31:0] reg_view(input logic [ADDR_W-1:0] a);
        logic [31:0] v;
        v = RST_ZERO;
        case (a)
            OFS_CONTROL_A: v[ENABLE_BIT] = enable_ff;
            OFS_DIVIDER: v[DIV_LSB +: DIV_W] = div_ff;
            OFS_TIMING: begin
                v[TICK_LSB +: TICK_W] = tick_ff;
                v[REF_LSB +: REF_W] = ref_ff;
            end
            OFS_HOLD: v[HOLD_LSB +: HOLD_W] = hold_ff;
            OFS_ACC_CTRL: begin
                v[CNT_LSB +: CNT_W] = cnt_sel_ff;
                v[REPEAT_BIT] = repeat_ff;
            end
            OFS_MUX_POS: v[MUX_LSB +: MUX_W] = pos_ff;
            OFS_MUX_NEG: v[MUX_LSB +: MUX_W] = neg_ff;
            OFS_COMMAND: begin
                v[START_LSB +: START_W] = start_ff;
                v[MODE_LSB +: MODE_W] = mode_ff;
                v[TWO_IN_BIT] = two_in_ff;
            end
            OFS_INT_EN: v[FLG_W-1:0] = inten_ff;
            OFS_INT_FLAG: v[FLG_W-1:0] = flags_ff;
            OFS_SAMPLE: v[15:0] = sample_ff;
            OFS_RESULT: v = result_ff;
            OFS_WIN_CTRL: v[WIN_MODE_LSB +: 3] = win_mode_ff;
            OFS_WIN_LO: v[THR_LSB +: THR_W] = win_lo_ff;
            OFS_WIN_HI: v[THR_LSB +: THR_W] = win_hi_ff;
            default: v = RST_ZERO;
        endcase
        return v;
    endfunction

    // write decode terms
    logic wr_fire, cmd_wr, mux_wr, start_now, abort, trig;
    logic [31:0] wr_val;
    logic [START_W-1:0] wr_start;
    assign wr_fire = !awready_ff && !wready_ff && !bvalid_ff;
    assign wr_val = merge(reg_view(waddr_ff), wdata_ff, wstrb_ff);
    assign wr_start = wr_val[START_LSB +: START_W];
    assign cmd_wr = wr_fire && (waddr_ff == OFS_COMMAND);
    assign mux_wr = wr_fire && (waddr_ff == OFS_MUX_POS || waddr_ff == OFS_MUX_NEG);
    assign start_now = cmd_wr && (wr_start == START_NOW);
    assign abort = cmd_wr && (wr_start == START_ABORT);
    // event path is gated by enable like the other starts, and acts only while clk_en is high
    assign trig = enable_ff && (start_now || (start_ff == START_EVENT && trig_event)
                  || (start_ff == START_MUXWR && mux_wr));

    // write channel: take address and data in any order, answer once both held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            waddr_ff <= '0;
            wdata_ff <= RST_ZERO;
            wstrb_ff <= '0;
        end else if (clk_en) begin
            if (awvalid && awready_ff) begin
                awready_ff <= 1'b0;
                waddr_ff <= awaddr;
            end
            if (wvalid && wready_ff) begin
                wready_ff <= 1'b0;
                wdata_ff <= wdata;
                wstrb_ff <= wstrb;
            end
            if (wr_fire) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= (waddr_ff <= OFS_WIN_HI && waddr_ff[1:0] == 2'h0) ?
                            RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_ff && bready) begin
                bvalid_ff <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff <= 1'b1;
            end
        end
    end

    // read channel: one cycle from address to data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= RST_ZERO;
            rresp_ff <= RESP_OKAY;
        end else if (clk_en) begin
            if (arvalid && arready_ff) begin
                arready_ff <= 1'b0;
                rvalid_ff <= 1'b1;
                rdata_ff <= reg_view(araddr);
                rresp_ff <= (araddr <= OFS_WIN_HI && araddr[1:0] == 2'h0) ?
                            RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_ff && rready) begin
                rvalid_ff <= 1'b0;
                arready_ff <= 1'b1;
            end
        end
    end

    // settings written by software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_ff <= 1'b0;
            div_ff <= '0;
            tick_ff <= '0;
            ref_ff <= '0;
            hold_ff <= '0;
            cnt_sel_ff <= '0;
            repeat_ff <= 1'b0;
            pos_ff <= '0;
            neg_ff <= '0;
            start_ff <= START_NONE;
            mode_ff <= MODE_SINGLE8;
            two_in_ff <= 1'b0;
            inten_ff <= '0;
            win_mode_ff <= WIN_OFF;
            win_lo_ff <= '0;
            win_hi_ff <= RST_WIN_HI;
        end else if (clk_en && wr_fire) begin
            case (waddr_ff)
                OFS_CONTROL_A: enable_ff <= wr_val[ENABLE_BIT];
                OFS_DIVIDER: div_ff <= wr_val[DIV_LSB +: DIV_W];
                OFS_TIMING: begin
                    tick_ff <= wr_val[TICK_LSB +: TICK_W];
                    ref_ff <= wr_val[REF_LSB +: REF_W];
                end
                OFS_HOLD: hold_ff <= wr_val[HOLD_LSB +: HOLD_W];
                OFS_ACC_CTRL: begin
                    cnt_sel_ff <= wr_val[CNT_LSB +: CNT_W];
                    repeat_ff <= wr_val[REPEAT_BIT];
                end
                OFS_MUX_POS: pos_ff <= wr_val[MUX_LSB +: MUX_W];
                OFS_MUX_NEG: neg_ff <= wr_val[MUX_LSB +: MUX_W];
                OFS_COMMAND: begin
                    start_ff <= wr_start;
                    mode_ff <= wr_val[MODE_LSB +: MODE_W];
                    two_in_ff <= wr_val[TWO_IN_BIT];
                end
                OFS_INT_EN: inten_ff <= wr_val[FLG_W-1:0];
                OFS_WIN_CTRL: win_mode_ff <= wr_val[WIN_MODE_LSB +: 3];
                OFS_WIN_LO: win_lo_ff <= wr_val[THR_LSB +: THR_W];
                OFS_WIN_HI: win_hi_ff <= wr_val[THR_LSB +: THR_W];
                default: enable_ff <= enable_ff;
            endcase
        end
    end

    // mode decode and sample shaping
    logic is_accum, is_burst, is_series, is_scaled, last, win_hit, below, above;
    logic [3:0] cnt_eff;
    logic [10:0] n_total;
    logic signed [12:0] clamped;
    logic [15:0] smp_val;
    logic signed [ACC_W-1:0] acc_sum, scaled;
    assign is_accum = mode_ff >= MODE_SERIES && mode_ff <= MODE_BURST_SC;
    assign is_series = mode_ff == MODE_SERIES || mode_ff == MODE_SERIES_SC;
    assign is_burst = mode_ff == MODE_BURST || mode_ff == MODE_BURST_SC;
    assign is_scaled = mode_ff == MODE_SERIES_SC || mode_ff == MODE_BURST_SC;
    assign cnt_eff = (4'(cnt_sel_ff) > CNT_MAX) ? CNT_MAX : 4'(cnt_sel_ff);
    assign n_total = 11'(1) << cnt_eff;
    assign last = done_cnt_ff == n_total - 11'(1);
    always_comb begin
        // clamp to the range of the chosen input type
        if (two_in_ff) begin
            clamped = (conv_in.code > DF_MAX) ? DF_MAX :
                      (conv_in.code < DF_MIN) ? DF_MIN : conv_in.code;
        end else begin
            clamped = (conv_in.code > SE_MAX) ? SE_MAX :
                      (conv_in.code < 0) ? 13'sh0000 : conv_in.code;
        end
        // eight-bit output only in mode 0, twelve otherwise
        if (mode_ff == MODE_SINGLE8) begin
            smp_val = two_in_ff ? {{8{clamped[11]}}, clamped[11:4]} : {8'h00, clamped[11:4]};
        end else begin
            smp_val = two_in_ff ? {{4{clamped[11]}}, clamped[11:0]} : {4'h0, clamped[11:0]};
        end
        // a new accumulation starts from zero
        acc_sum = ((done_cnt_ff == 11'h000) ? '0 : acc_ff)
                  + {{(ACC_W-16){smp_val[15]}}, smp_val};
        scaled = (cnt_eff >= SCALE_BASE) ? (acc_sum >>> (cnt_eff - SCALE_BASE))
                 : (acc_sum <<< (SCALE_BASE - cnt_eff));
        // window compare in the sample's own number format
        below = two_in_ff ? ($signed(smp_val) < $signed(win_lo_ff)) : (smp_val < win_lo_ff);
        above = two_in_ff ? ($signed(smp_val) > $signed(win_hi_ff)) : (smp_val > win_hi_ff);
        case (win_mode_ff)
            WIN_BELOW: win_hit = below;
            WIN_ABOVE: win_hit = above;
            WIN_INSIDE: win_hit = !below && !above;
            WIN_OUTSIDE: win_hit = below || above;
            default: win_hit = 1'b0;
        endcase
    end

    // conversion sequencer
    logic finish;
    assign finish = state_ff == ST_BUSY && conv_in.done && !abort;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= ST_IDLE;
            done_cnt_ff <= '0;
            acc_ff <= '0;
            conv_start_ff <= 1'b0;
            conv_abort_ff <= 1'b0;
        end else if (clk_en) begin
            conv_start_ff <= 1'b0;
            conv_abort_ff <= 1'b0;
            if (abort) begin
                // drop the partial sum, ready for a new trigger next cycle
                state_ff <= ST_IDLE;
                done_cnt_ff <= '0;
                acc_ff <= '0;
                conv_abort_ff <= 1'b1;
            end else if (state_ff == ST_IDLE) begin
                if (trig) begin
                    state_ff <= ST_BUSY;
                    conv_start_ff <= 1'b1;
                end
            end else if (finish) begin
                acc_ff <= is_accum ? acc_sum : '0;
                done_cnt_ff <= (is_accum && !last) ? done_cnt_ff + 11'(1) : '0;
                if (is_burst && !last) begin
                    conv_start_ff <= 1'b1;
                end else if (repeat_ff && enable_ff && !is_series) begin
                    conv_start_ff <= 1'b1;
                end else begin
                    state_ff <= ST_IDLE;
                end
            end
        end
    end

    // sample, result and sticky flags; set wins over software clear
    logic [FLG_W-1:0] flg_set, flg_clr;
    always_comb begin
        flg_set = '0;
        flg_set[FLG_SMP] = finish;
        flg_set[FLG_RES] = finish && (!is_accum || last);
        flg_set[FLG_WIN] = finish && win_hit;
        flg_set[FLG_OVR] = trig && state_ff == ST_BUSY && !abort;
        flg_clr = (wr_fire && waddr_ff == OFS_INT_FLAG) ?
                  (wdata_ff[FLG_W-1:0] & {FLG_W{wstrb_ff[0]}}) : '0;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sample_ff <= '0;
            result_ff <= RST_ZERO;
            flags_ff <= '0;
            irq_ff <= 1'b0;
        end else if (clk_en) begin
            flags_ff <= (flags_ff & ~flg_clr) | flg_set;
            irq_ff <= |(flags_ff & inten_ff);
            if (finish) begin
                sample_ff <= smp_val;
                if (!is_accum) begin
                    result_ff <= {{16{smp_val[15]}}, smp_val};
                end else if (last) begin
                    result_ff <= is_scaled ? 32'(scaled) : 32'(acc_sum);
                end
            end
        end
    end

    // outputs straight from flops
    assign awready = awready_ff;
    assign wready = wready_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign arready = arready_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;
    assign conv_start = conv_start_ff;
    assign conv_abort = conv_abort_ff;
    assign irq = irq_ff;
    assign afe_cfg = '{enable_ff, ref_ff, div_ff, tick_ff, hold_ff, pos_ff, neg_ff, two_in_ff};

    // checks
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn || !clk_en);
    trig_overrun_a: assert property (trig && state_ff == ST_BUSY && !abort |=>
        flags_ff[FLG_OVR]) else $error("overrun flag missing");
    start_now_a: assert property (start_now && enable_ff && state_ff == ST_IDLE |=>
        conv_start_ff && state_ff == ST_BUSY) else $error("start-now did not start");
    abort_clean_a: assert property (abort |=> state_ff == ST_IDLE && done_cnt_ff == 11'h000
        && !conv_start_ff && $stable(result_ff)) else $error("abort left work behind");
    series_wait_a: assert property (finish && is_series |=> !conv_start_ff)
        else $error("series step started without trigger");
    burst_next_a: assert property (finish && is_burst && !last |=> conv_start_ff
        && state_ff == ST_BUSY) else $error("burst did not continue");
    result_hold_a: assert property (finish && is_accum && !last |=> $stable(result_ff)
        && !flags_ff[FLG_RES] || $past(flags_ff[FLG_RES])) else $error("early result");
    single_result_a: assert property (finish && !is_accum |=>
        result_ff[15:0] == sample_ff && flags_ff[FLG_RES]) else $error("single result wrong");
    clamp_range_a: assert property (!two_in_ff && finish |=> sample_ff <= 16'h0FFF)
        else $error("single-ended sample out of range");
    irq_gate_a: assert property (!(|(flags_ff & inten_ff)) |=> !irq_ff)
        else $error("interrupt without enabled flag");
endmodule
`default_nettype wire

/* File: verification/adc_conversion_sequencer_bench.sv */
// bench: register-driven conversion scenarios
`default_nettype none
module adc_conversion_sequencer_bench;
    import adc_seq_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
    logic rready = 0, trig_event = 0, awready, wready, bvalid, arready, rvalid;
    logic conv_start, conv_abort, irq;
    logic [ADDR_W-1:0] awaddr = 0, araddr = 0;
    logic [DATA_W-1:0] wdata = 0, rdata, seed = 32'h6F53284D;
    logic [1:0] bresp, rresp;
    logic [12:0] code_v = 0;
    conv_in_t conv_in;
    afe_cfg_t afe_cfg;
    logic [33:0] exp_q[$]; // expected {rresp, rdata}
    int bad_count = 0, checks = 0, cyc = 0;
    always #50 aclk = ~aclk;
    adc_conversion_sequencer dut_u (.clk_en(1'b1), .wstrb(4'hF), .*);
    adc_core_model core_u (.*);
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [31:0] cmd(input logic [2:0] m, input logic [2:0] s, input logic d);
        return {24'h0, d, m, 1'b0, s};
    endfunction
    // axi write: both channels offered together, released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        fork
            begin do @(posedge aclk); while (!awready); awvalid <= 0; end
            begin do @(posedge aclk); while (!wready); wvalid <= 0; end
        join
        do @(posedge aclk); while (!bvalid);
        bready <= 0;
    endtask
    // axi read, expectation queued for the monitor
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        exp_q.push_back(e);
        araddr <= a; arvalid <= 1; rready <= 1;
        do @(posedge aclk); while (!arready);
        arvalid <= 0;
        do @(posedge aclk); while (!rvalid);
        rready <= 0;
    endtask
    // start now, wait, then check the result
    task automatic conv(input logic [2:0] m, input logic d, input logic [12:0] k,
                        input logic [31:0] e);
        code_v <= k;
        wr(OFS_COMMAND, cmd(m, START_NOW, d));
        repeat (90) @(posedge aclk);
        rd(OFS_RESULT, {RESP_OKAY, e});
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // monitor: compare each read beat with the oldest note
    always @(posedge aclk) begin
        if (rvalid && rready) begin
            checks++;
            if (exp_q.size() == 0 || {rresp, rdata} !== exp_q[0]) begin
                bad_count++;
                $display("Error at %0t: read %h", $time, {rresp, rdata});
            end
            if (exp_q.size() > 0) void'(exp_q.pop_front());
        end
    end
    // hang guard
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin bad_count++; report_and_stop(); end
    end
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        wr(OFS_CONTROL_A, 32'h1);
        rd(8'h3C, {RESP_SLVERR, 32'h0});
        seed = lfsr(seed);
        conv(MODE_SINGLE12, 0, {1'b0, seed[11:0]}, {20'h0, seed[11:0]});
        rd(OFS_INT_FLAG, {RESP_OKAY, 32'h3});
        conv(MODE_SINGLE8, 0, 13'h0ABC, 32'hAB);
        conv(MODE_SINGLE12, 0, 13'h1FFB, 32'h0);
        conv(MODE_SINGLE12, 1, 13'h1FFB, 32'hFFFFFFFB);
        wr(OFS_ACC_CTRL, 32'h2);
        conv(MODE_BURST, 0, 13'h100, 32'h400);
        conv(MODE_BURST_SC, 0, 13'h100, 32'h1000);
        // series with repeat set: still one trigger per step
        wr(OFS_ACC_CTRL, 32'h22);
        code_v <= 13'h010;
        repeat (3) begin
            wr(OFS_COMMAND, cmd(MODE_SERIES, START_NOW, 0));
            repeat (20) @(posedge aclk);
        end
        rd(OFS_RESULT, {RESP_OKAY, 32'h1000});
        conv(MODE_SERIES, 0, 13'h010, 32'h40);
        wr(OFS_ACC_CTRL, 32'h2);
        wr(OFS_INT_FLAG, 32'hF);
        wr(OFS_COMMAND, cmd(MODE_BURST, START_NOW, 0));
        conv(MODE_BURST, 0, 13'h010, 32'h40);
        rd(OFS_INT_FLAG, {RESP_OKAY, 32'hB});
        // free-running single: flags come back after a clear, no new trigger
        wr(OFS_ACC_CTRL, 32'h20);
        wr(OFS_COMMAND, cmd(MODE_SINGLE12, START_NOW, 0));
        repeat (30) @(posedge aclk);
        wr(OFS_INT_FLAG, 32'hF);
        repeat (30) @(posedge aclk);
        rd(OFS_INT_FLAG, {RESP_OKAY, 32'h3});
        wr(OFS_COMMAND, cmd(MODE_SINGLE12, START_ABORT, 0));
        // abort mid-conversion: no flags after 20 cycles, restart after the flag read
        wr(OFS_ACC_CTRL, 32'h0);
        wr(OFS_INT_FLAG, 32'hF);
        wr(OFS_COMMAND, cmd(MODE_SINGLE12, START_NOW, 0));
        wr(OFS_COMMAND, cmd(MODE_SINGLE12, START_ABORT, 0));
        repeat (20) @(posedge aclk);
        rd(OFS_INT_FLAG, {RESP_OKAY, 32'h0});
        conv(MODE_SINGLE12, 0, 13'h123, 32'h123);
        // event and mux-write triggers
        code_v <= 13'h055;
        wr(OFS_COMMAND, cmd(MODE_SINGLE12, START_EVENT, 0));
        trig_event <= 1;
        @(posedge aclk);
        trig_event <= 0;
        repeat (20) @(posedge aclk);
        rd(OFS_RESULT, {RESP_OKAY, 32'h55});
        code_v <= 13'h066;
        wr(OFS_COMMAND, cmd(MODE_SINGLE12, START_MUXWR, 0));
        wr(OFS_MUX_POS, 32'h3);
        repeat (20) @(posedge aclk);
        rd(OFS_RESULT, {RESP_OKAY, 32'h66});
        $display("test sequence finished");
        report_and_stop();
    end
endmodule
`default_nettype wire

/* File: verification/adc_core_model.sv */
// analog core stand-in: answers each start with one done pulse
`default_nettype none
module adc_core_model
    import adc_seq_pkg::*;
#(
    parameter int DLY = 8 // cycles from start to done
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic conv_start,
    input wire logic conv_abort,
    input wire logic [12:0] code_v,
    output var conv_in_t conv_in
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt_ff; // cycles left, 0 when idle
    // countdown, cut short by abort
    always_ff @(posedge aclk) begin
        if (!aresetn || conv_abort) begin
            cnt_ff <= 0;
        end else if (conv_start) begin
            cnt_ff <= DLY;
        end else if (cnt_ff > 0) begin
            cnt_ff <= cnt_ff - 1;
        end
    end
    // code is valid only with done, junk otherwise
    always_comb begin
        conv_in.done = (cnt_ff == 1);
        conv_in.code = (cnt_ff == 1) ? code_v : ~code_v;
    end
endmodule
`default_nettype wire
